// ### adc_i2c_pkg.sv
// Purpose: Shared constants for the two-wire converter target
// Assumes: System clock of 100 MHz, link sampled by it
// Notes: Address prefix and command fields
`default_nettype none
package adc_i2c_pkg;
   localparam logic [4:0] ADDR_PREFIX = 5'h12;
   localparam int CMD_SEL_POS = 7;
   localparam int CMD_CH_POS = 4;
   localparam int CMD_PWR_POS = 2;
   localparam logic [7:0] RESULT_RESET = 8'h00;
   localparam logic [7:0] CMD_RESET = 8'h00;
   localparam int SAR_BITS = 8;
   localparam int ACQ_CYCLES = 4;
   localparam int PHASE_CYCLES = 2;
   localparam logic [3:0] BIT_COUNT_ACK = 4'h8;
   typedef enum logic [1:0] {CONV_IDLE, CONV_ACQ, CONV_PH1, CONV_PH2} conv_state_t;
   typedef enum logic [2:0] {BUS_IDLE, BUS_ADDR, BUS_ADDR_ACK, BUS_WRITE, BUS_WACK,
      BUS_READ, BUS_RACK} bus_state_t;
endpackage
`default_nettype wire

// ### adc_i2c_target.sv
// Purpose: Two-wire target front end and converter control
// Assumes: Link pins sampled by clk_sys through two flip-flops
// Notes: Clock stretch used only in high speed mode
`default_nettype none
module adc_i2c_target
   import adc_i2c_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output logic scl_out,
   output logic scl_oe,
   input wire logic addr_strap_hi,
   input wire logic addr_strap_lo,
   input wire logic high_speed_mode,
   input wire logic comparator_high,
   output logic input_type_select,
   output logic [2:0] channel_select,
   output logic [1:0] power_ref_control,
   output logic core_power_on,
   output logic core_clock_on,
   output logic acquire,
   output logic phase_ground,
   output logic phase_apply,
   output logic [SAR_BITS-1:0] trial_bits
);
   typedef struct packed {
      logic [1:0] scl_sync;
      logic [1:0] sda_sync;
      logic scl_d;
      logic sda_d;
      bus_state_t st;
      logic [3:0] bitcnt;
      logic [7:0] shreg;
      logic [7:0] txreg;
      logic strap_done;
      logic [1:0] strap;
      logic [1:0] strap_meta;
      logic [1:0] strap_pin;
      logic addressed;
      logic [7:0] cmd;
      logic conv_req;
      logic stretch;
      logic sda_out;
      logic sda_oe;
      logic scl_oe;
      logic input_type_select;
      logic [2:0] channel_select;
      logic [1:0] power_ref_control;
      logic core_on;
      logic acquire;
      logic ph1;
      logic ph2;
      logic [SAR_BITS-1:0] trial;
   } tgt_t;
   tgt_t s, next_s;

   logic scl, sda, scl_rise, scl_fall, start_seen, stop_seen;
   logic sar_busy, sar_done, sar_acq, sar_ph1, sar_ph2;
   logic [SAR_BITS-1:0] sar_trial, sar_result;
   logic [6:0] own_addr;

   assign scl = s.scl_sync[1];
   assign sda = s.sda_sync[1];
   assign scl_rise = scl && !s.scl_d;
   assign scl_fall = !scl && s.scl_d;
   assign start_seen = scl && s.scl_d && s.sda_d && !sda;
   assign stop_seen = scl && s.scl_d && !s.sda_d && sda;
   assign own_addr = {ADDR_PREFIX, s.strap};

   sar_sequencer u_sar (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .start(s.conv_req),
      .comparator_high(comparator_high),
      .busy(sar_busy),
      .done(sar_done),
      .acquire(sar_acq),
      .phase_ground(sar_ph1),
      .phase_apply(sar_ph2),
      .trial(sar_trial),
      .result(sar_result)
   );

   always_comb begin
      next_s = s;
      next_s.scl_sync = {s.scl_sync[0], scl_in};
      next_s.sda_sync = {s.sda_sync[0], sda_in};
      next_s.strap_meta = {addr_strap_hi, addr_strap_lo};
      next_s.strap_pin = s.strap_meta;
      next_s.scl_d = scl;
      next_s.sda_d = sda;
      next_s.conv_req = 1'b0;
      next_s.acquire = sar_acq;
      next_s.ph1 = sar_ph1;
      next_s.ph2 = sar_ph2;
      next_s.trial = sar_trial;
      // Data settles one cycle before the clock is freed
      if (!sar_busy && !sar_done && s.stretch && !s.conv_req) begin
         next_s.stretch = 1'b0;
      end
      next_s.scl_oe = next_s.stretch;
      if (start_seen) begin
         next_s.st = BUS_ADDR;
         next_s.bitcnt = 4'h0;
         next_s.sda_oe = 1'b0;
         next_s.addressed = 1'b0;
      end else if (stop_seen) begin
         next_s.st = BUS_IDLE;
         next_s.sda_oe = 1'b0;
         next_s.addressed = 1'b0;
      end else if (scl_rise) begin
         unique case (s.st)
            BUS_ADDR, BUS_WRITE: begin
               next_s.shreg = {s.shreg[6:0], sda};
               next_s.bitcnt = s.bitcnt + 4'h1;
               if (s.st == BUS_ADDR && s.bitcnt == 4'h7 && !s.strap_done) begin
                  next_s.strap = s.strap_pin;
                  next_s.strap_done = 1'b1;
               end
               if (s.st == BUS_WRITE && s.bitcnt == 4'h3 && !high_speed_mode) begin
                  next_s.conv_req = 1'b1;
               end
            end
            BUS_READ: begin
               next_s.bitcnt = s.bitcnt + 4'h1;
            end
            BUS_RACK: begin
               if (sda) begin
                  next_s.st = BUS_IDLE;
               end else begin
                  next_s.st = BUS_READ;
                  next_s.bitcnt = 4'h0;
               end
            end
            default: begin
            end
         endcase
      end else if (scl_fall) begin
         unique case (s.st)
            BUS_ADDR: begin
               if (s.bitcnt == BIT_COUNT_ACK) begin
                  if (s.shreg[7:1] == own_addr) begin
                     next_s.st = BUS_ADDR_ACK;
                     next_s.addressed = 1'b1;
                     next_s.sda_out = 1'b0;
                     next_s.sda_oe = 1'b1;
                  end else begin
                     next_s.st = BUS_IDLE;
                  end
               end
            end
            BUS_ADDR_ACK: begin
               next_s.bitcnt = 4'h0;
               if (s.shreg[0]) begin
                  next_s.st = BUS_READ;
                  next_s.txreg = sar_result;
                  next_s.sda_out = sar_result[7];
                  next_s.sda_oe = !sar_result[7];
                  if (high_speed_mode) begin
                     next_s.stretch = 1'b1;
                     next_s.conv_req = 1'b1;
                     next_s.scl_oe = 1'b1;
                  end
               end else begin
                  next_s.st = BUS_WRITE;
                  next_s.sda_oe = 1'b0;
               end
            end
            BUS_WRITE: begin
               if (s.bitcnt == BIT_COUNT_ACK) begin
                  next_s.st = BUS_WACK;
                  next_s.cmd = s.shreg;
                  next_s.input_type_select = s.shreg[CMD_SEL_POS];
                  next_s.channel_select = s.shreg[CMD_CH_POS +: 3];
                  next_s.power_ref_control = s.shreg[CMD_PWR_POS +: 2];
                  next_s.sda_out = 1'b0;
                  next_s.sda_oe = 1'b1;
               end
            end
            BUS_WACK: begin
               next_s.st = BUS_WRITE;
               next_s.bitcnt = 4'h0;
               next_s.sda_oe = 1'b0;
            end
            BUS_READ: begin
               if (s.bitcnt == BIT_COUNT_ACK) begin
                  next_s.st = BUS_RACK;
                  next_s.sda_oe = 1'b0;
                  next_s.txreg = sar_result;
               end else begin
                  next_s.sda_out = s.txreg[3'(7 - s.bitcnt)];
                  next_s.sda_oe = !s.txreg[3'(7 - s.bitcnt)];
               end
            end
            BUS_RACK: begin
               next_s.sda_oe = 1'b0;
            end
            default: begin
            end
         endcase
      end
      // High speed read data refreshed after the stretched conversion
      if (sar_done && s.st == BUS_READ && s.bitcnt == 4'h0) begin
         next_s.txreg = sar_result;
         next_s.sda_out = sar_result[7];
         next_s.sda_oe = !sar_result[7];
      end
      next_s.core_on = sar_busy || next_s.conv_req || next_s.addressed;
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         s <= '0;
         s.scl_sync <= 2'h3;
         s.sda_sync <= 2'h3;
         s.scl_d <= 1'b1;
         s.sda_d <= 1'b1;
         s.st <= BUS_IDLE;
         s.cmd <= CMD_RESET;
         s.sda_out <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign sda_out = s.sda_out;
   assign sda_oe = s.sda_oe;
   assign scl_out = 1'b0;
   assign scl_oe = s.scl_oe;
   assign input_type_select = s.input_type_select;
   assign channel_select = s.channel_select;
   assign power_ref_control = s.power_ref_control;
   assign core_power_on = s.core_on;
   assign core_clock_on = s.core_on;
   assign acquire = s.acquire;
   assign phase_ground = s.ph1;
   assign phase_apply = s.ph2;
   assign trial_bits = s.trial;

   // Link is oversampled; all speeds work while clk_sys exceeds six times SCL

   sequence stop_event;
      stop_seen;
   endsequence
   sequence conv_quiet;
      !sar_busy ##1 (!s.conv_req && !s.addressed);
   endsequence
   sequence read_start;
      s.st == BUS_ADDR_ACK && scl_fall && s.shreg[0];
   endsequence
   sequence hs_read_start;
      s.st == BUS_ADDR_ACK && scl_fall && s.shreg[0] && high_speed_mode;
   endsequence
   sequence stretch_grab;
      scl_oe ##1 (scl_oe && sar_busy);
   endsequence
   sequence cmd_nibble;
      s.st == BUS_WRITE && scl_rise && s.bitcnt == 4'h3 && !high_speed_mode;
   endsequence

   chk_stop_idle: assert property (@(posedge clk_sys) disable iff (!reset_n)
      stop_event |=> (s.st == BUS_IDLE && !sda_oe))
      else $error("stop did not idle bus");
   chk_start_addr: assert property (@(posedge clk_sys) disable iff (!reset_n)
      start_seen |=> (s.st == BUS_ADDR && s.bitcnt == 4'h0))
      else $error("start not taken");
   chk_ack_match: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (s.st == BUS_ADDR && scl_fall && s.bitcnt == BIT_COUNT_ACK && !start_seen
       && s.shreg[7:1] == own_addr) |=> (sda_oe && !sda_out))
      else $error("matching address not acknowledged");
   chk_addr_miss: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (s.st == BUS_ADDR && scl_fall && s.bitcnt == BIT_COUNT_ACK
       && s.shreg[7:1] != own_addr) |=> (s.st == BUS_IDLE && !sda_oe))
      else $error("foreign address not ignored");
   chk_strap_latch: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (s.st == BUS_ADDR && scl_rise && s.bitcnt == 4'h7 && !s.strap_done)
      |=> (s.strap_done && s.strap == $past(s.strap_pin)))
      else $error("straps not latched at eighth rise");
   chk_strap_once: assert property (@(posedge clk_sys) disable iff (!reset_n)
      s.strap_done |=> $stable(s.strap))
      else $error("straps latched twice");
   chk_dir_write: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (s.st == BUS_ADDR_ACK && scl_fall && !s.shreg[0])
      |=> (s.st == BUS_WRITE && !sda_oe))
      else $error("write direction not taken");
   chk_dir_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
      read_start |=> (s.st == BUS_READ && s.txreg == $past(sar_result)))
      else $error("read not loaded with latest result");
   chk_cmd_fields: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (s.st == BUS_WRITE && scl_fall && s.bitcnt == BIT_COUNT_ACK)
      |=> (channel_select == $past(s.shreg[CMD_CH_POS +: 3])
       && input_type_select == $past(s.shreg[CMD_SEL_POS]) && sda_oe))
      else $error("command fields not taken");
   chk_read_ack_slot: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (s.st == BUS_READ && scl_fall && s.bitcnt == BIT_COUNT_ACK)
      |=> (s.st == BUS_RACK && !sda_oe))
      else $error("read byte not nine clocks");
   chk_nack_end: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (s.st == BUS_RACK && scl_rise && sda) |=> s.st == BUS_IDLE)
      else $error("no-acknowledge did not end read");
   chk_conv_start: assert property (@(posedge clk_sys) disable iff (!reset_n)
      cmd_nibble |-> ##2 sar_busy)
      else $error("conversion not started by command");
   chk_power_idle: assert property (@(posedge clk_sys) disable iff (!reset_n)
      conv_quiet |-> (!core_power_on && !core_clock_on))
      else $error("core powered while idle");
   chk_power_busy: assert property (@(posedge clk_sys) disable iff (!reset_n)
      sar_busy |=> core_power_on)
      else $error("core off during conversion");
   chk_stretch_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (s.stretch && sar_busy) |-> scl_oe)
      else $error("clock released during conversion");
   chk_stretch_grab: assert property (@(posedge clk_sys) disable iff (!reset_n)
      hs_read_start |=> stretch_grab)
      else $error("clock not held for read conversion");
   chk_stretch_release: assert property (@(posedge clk_sys) disable iff (!reset_n)
      $fell(scl_oe) |-> ($past(sar_done, 2) && $stable(sda_oe)))
      else $error("clock freed before data settled");
endmodule
`default_nettype wire

// ### bus_ctrl_model.sv
// Purpose: Bus controller model for the converter target
// Assumes: Open drain lines with pull-ups
// Notes: Bus clock period 125 ns, waits out a stretched clock
`default_nettype none
module bus_ctrl_model (
   input wire logic scl_line,
   input wire logic sda_line,
   output logic scl_pull,
   output logic sda_pull
);
   timeunit 1ns;
   timeprecision 10ps;
   localparam real Q = 31.25;
   initial begin
      scl_pull = 1'b0;
      sda_pull = 1'b0;
   end
   // Release clock, wait out any stretch
   task automatic rise();
      int n;
      #Q scl_pull = 1'b0;
      n = 0;
      while (scl_line !== 1'b1 && n < 9000) begin
         #10;
         n++;
      end
   endtask
   // One bit, data changed only while clock low
   task automatic bit_io(input logic d, output logic s);
      #Q sda_pull = ~d;
      rise();
      #Q s = sda_line;
      #Q scl_pull = 1'b1;
   endtask
   // Start: data falls while clock high
   task automatic start_cond();
      #Q sda_pull = 1'b0;
      rise();
      #Q sda_pull = 1'b1;
      #Q scl_pull = 1'b1;
   endtask
   // Stop: data rises while clock high
   task automatic stop_cond();
      #Q sda_pull = 1'b1;
      rise();
      #Q sda_pull = 1'b0;
      #(4 * Q);
   endtask
   // Eight bits top first, then the acknowledge slot
   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], s);
      end
      bit_io(1'b1, s);
      ack = ~s;
   endtask
   // Receive a byte, then acknowledge or decline
   task automatic recv_byte(input logic ack, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, s);
         b[i] = s;
      end
      bit_io(~ack, s);
   endtask
endmodule
`default_nettype wire

// ### sar_sequencer.sv
// Purpose: Successive approximation bit decision sequencer
// Assumes: Comparator output is valid during the second phase
// Notes: Acquisition, then two non-overlapping phases per bit
`default_nettype none
module sar_sequencer
   import adc_i2c_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic start,
   input wire logic comparator_high,
   output logic busy,
   output logic done,
   output logic acquire,
   output logic phase_ground,
   output logic phase_apply,
   output logic [SAR_BITS-1:0] trial,
   output logic [SAR_BITS-1:0] result
);
   typedef struct packed {
      conv_state_t st;
      logic [2:0] cnt;
      logic [2:0] bit_idx;
      logic [SAR_BITS-1:0] trial;
      logic [SAR_BITS-1:0] result;
      logic done;
   } sar_t;
   sar_t s, next_s;

   always_comb begin
      next_s = s;
      next_s.done = 1'b0;
      unique case (s.st)
         CONV_IDLE: begin
            if (start) begin
               next_s.st = CONV_ACQ;
               next_s.cnt = 3'(ACQ_CYCLES - 1);
            end
         end
         CONV_ACQ: begin
            if (s.cnt == 3'h0) begin
               next_s.st = CONV_PH1;
               next_s.cnt = 3'(PHASE_CYCLES - 1);
               next_s.bit_idx = 3'(SAR_BITS - 1);
               next_s.trial = {1'b1, {(SAR_BITS-1){1'b0}}};
            end else begin
               next_s.cnt = s.cnt - 3'h1;
            end
         end
         CONV_PH1: begin
            if (s.cnt == 3'h0) begin
               next_s.st = CONV_PH2;
               next_s.cnt = 3'(PHASE_CYCLES - 1);
            end else begin
               next_s.cnt = s.cnt - 3'h1;
            end
         end
         CONV_PH2: begin
            if (s.cnt != 3'h0) begin
               next_s.cnt = s.cnt - 3'h1;
            end else begin
               next_s.trial[s.bit_idx] = comparator_high;
               if (s.bit_idx == 3'h0) begin
                  next_s.st = CONV_IDLE;
                  next_s.result = {s.trial[SAR_BITS-1:1], comparator_high};
                  next_s.done = 1'b1;
               end else begin
                  next_s.trial[s.bit_idx - 3'h1] = 1'b1;
                  next_s.bit_idx = s.bit_idx - 3'h1;
                  next_s.st = CONV_PH1;
                  next_s.cnt = 3'(PHASE_CYCLES - 1);
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         s <= '{CONV_IDLE, 3'h0, 3'h0, RESULT_RESET, RESULT_RESET, 1'b0};
      end else begin
         s <= next_s;
      end
   end

   assign busy = (s.st != CONV_IDLE);
   assign done = s.done;
   assign acquire = (s.st == CONV_ACQ);
   assign phase_ground = (s.st == CONV_PH1);
   assign phase_apply = (s.st == CONV_PH2);
   assign trial = s.trial;
   assign result = s.result;

   chk_msb_first_trial: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (s.st == CONV_ACQ && s.cnt == 3'h0) |=> (s.trial == 8'h80))
      else $error("first trial not msb only");
   chk_phases_apart: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !(phase_ground && phase_apply))
      else $error("phases overlap");
   chk_eight_periods: assert property (@(posedge clk_sys) disable iff (!reset_n)
      $rose(phase_ground) && s.bit_idx == 3'h7 |-> ##[30:34] done)
      else $error("conversion not eight periods");
endmodule
`default_nettype wire

// ### testbench.sv
// Purpose: Self-checking bench for the two-wire converter target
// Assumes: Comparator follows a modelled input level
// Notes: Bus controller model drives the link
`default_nettype none
module testbench
   import adc_i2c_pkg::*;
();
   timeunit 1ns;
   timeprecision 10ps;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic addr_strap_hi = 1'b1;
   logic addr_strap_lo = 1'b0;
   logic high_speed_mode = 1'b0;
   logic comparator_high = 1'b0;
   logic [7:0] vin = 8'h5b;
   wire logic scl_line;
   wire logic sda_line;
   logic scl_pull, sda_pull, sda_out, sda_oe, scl_out, scl_oe;
   logic input_type_select, core_power_on, core_clock_on;
   logic acquire, phase_ground, phase_apply, apply_q, ground_q;
   logic [7:0] grounds = 8'h00;
   logic [2:0] channel_select;
   logic [1:0] power_ref_control;
   logic [SAR_BITS-1:0] trial_bits;
   logic acq_seen = 1'b0;
   logic stretch_seen = 1'b0;
   logic [7:0] applied[$];
   int err_count = 0;
   int checked = 0;
   always #5 clk_sys = ~clk_sys;
   assign scl_line = ~(scl_pull | (scl_oe & ~scl_out));
   assign sda_line = ~(sda_pull | (sda_oe & ~sda_out));
   // Comparator and activity monitors
   always @(posedge clk_sys) begin
      comparator_high <= (trial_bits <= vin);
      apply_q <= phase_apply;
      ground_q <= phase_ground;
      if (phase_ground === 1'b1 && ground_q !== 1'b1) grounds <= grounds + 8'h01;
      if (acquire === 1'b1) acq_seen <= 1'b1;
      if (scl_oe === 1'b1) stretch_seen <= 1'b1;
      if (phase_apply === 1'b1 && apply_q !== 1'b1) applied.push_back(trial_bits);
   end
   adc_i2c_target i_adc_i2c_target (
      .clk_sys(clk_sys), .reset_n(reset_n), .scl_in(scl_line), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe(sda_oe), .scl_out(scl_out), .scl_oe(scl_oe),
      .addr_strap_hi(addr_strap_hi), .addr_strap_lo(addr_strap_lo),
      .high_speed_mode(high_speed_mode), .comparator_high(comparator_high),
      .input_type_select(input_type_select), .channel_select(channel_select),
      .power_ref_control(power_ref_control), .core_power_on(core_power_on),
      .core_clock_on(core_clock_on), .acquire(acquire), .phase_ground(phase_ground),
      .phase_apply(phase_apply), .trial_bits(trial_bits)
   );
   bus_ctrl_model i_bus_ctrl_model (
      .scl_line(scl_line), .sda_line(sda_line),
      .scl_pull(scl_pull), .sda_pull(sda_pull)
   );
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("Counts: %0d compares, %0d mismatches", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Address with write direction, then command byte
   task automatic write_cmd(input logic [6:0] a, input logic ea, input logic eq);
      logic ack;
      i_bus_ctrl_model.start_cond();
      i_bus_ctrl_model.send_byte({a, 1'b0}, ack);
      check(8'(ack), 8'(ea));
      if (ea) begin
         @(posedge clk_sys) acq_seen <= 1'b0;
         i_bus_ctrl_model.send_byte(8'hb6, ack);
         check(8'(ack), 8'h01);
         check(8'(acq_seen), 8'(eq));
      end
      i_bus_ctrl_model.stop_cond();
   endtask
   // Address with read direction, then result bytes
   task automatic read_res(input int nb, input logic [7:0] exp);
      logic ack;
      logic [7:0] b;
      i_bus_ctrl_model.start_cond();
      i_bus_ctrl_model.send_byte({7'h4a, 1'b1}, ack);
      check(8'(ack), 8'h01);
      for (int i = 0; i < nb; i++) begin
         i_bus_ctrl_model.recv_byte(i < nb - 1, b);
         check(b, exp);
      end
      i_bus_ctrl_model.stop_cond();
   endtask
   task automatic wait_conv();
      for (int n = 0; n < 3000 && applied.size() < 8; n++) @(posedge clk_sys);
      repeat (10) @(posedge clk_sys);
      check(8'(applied.size()), 8'h08);
      check(grounds, 8'h08);
   endtask
   initial begin
      repeat (20) @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      check(8'({scl_out, sda_oe, scl_oe, core_power_on, core_clock_on}), 8'h00);
      write_cmd(7'h4a, 1'b1, 1'b1);
      check(8'({input_type_select, channel_select, power_ref_control}), 8'h2d);
      wait_conv();
      check(applied[0], 8'h80);
      check(applied[1], 8'h40);
      check(applied[7], 8'h5b);
      check(8'({core_power_on, core_clock_on}), 8'h00);
      $display("test conversion done");
      @(posedge clk_sys);
      addr_strap_hi <= 1'b0;
      addr_strap_lo <= 1'b1;
      for (int a = 0; a < 4; a++) begin
         write_cmd(7'(7'h48 + a), a == 2, a == 2);
      end
      $display("test address done");
      read_res(1, 8'h5b);
      read_res(2, 8'h5b);
      $display("test read done");
      @(posedge clk_sys);
      high_speed_mode <= 1'b1;
      vin <= 8'hc6;
      write_cmd(7'h4a, 1'b1, 1'b0);
      @(posedge clk_sys);
      stretch_seen <= 1'b0;
      grounds <= 8'h00;
      applied.delete();
      read_res(1, 8'hc6);
      check(8'(stretch_seen), 8'h01);
      wait_conv();
      $display("test high speed done");
      close_out();
   end
   initial begin
      #500000;
      err_count++;
      close_out();
   end
endmodule
`default_nettype wire
